/* serial_channel_defines.svh */
// Offsets, field positions, reset values and encodings for the serial channel status block.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
`ifndef SERIAL_CHANNEL_DEFINES_SVH
`define SERIAL_CHANNEL_DEFINES_SVH

`define OFF_RECEIVE_STATUS 12'h000
`define OFF_LINE_STATUS 12'h004
`define OFF_MODE_CTRL 12'h008
`define OFF_COMMAND 12'h00C

// Receive status bit positions
`define RS_EOM 7
`define RS_PMP 6
`define RS_PE 5
`define RS_FRAMING_ERROR_FLAG 4
`define RS_OVERRUN_FLAG 3
`define RS_CRC_ERROR_FLAG 2

// Line status bit positions
`define LS_TXING 5
`define LS_SEARCH_MODE_INDICATOR 4
`define LS_CTS 3
`define LS_DCD 2
`define LS_TXEN 1
`define LS_RXEN 0

// Mode control fields: [1:0] channel mode, [3:2] parity capture select, [4] crc pass
`define MC_MODE_LO 0
`define MC_PSEL_LO 2
`define MC_CRCPASS 4
`define MODE_CTRL_RESET 8'h00

// Command codes, written to the command register low byte
`define CMD_NOP 8'h00
`define CMD_TX_RESET 8'h01
`define CMD_RX_RESET 8'h02
`define CMD_CH_RESET 8'h03
`define CMD_TX_ENABLE 8'h04
`define CMD_TX_DISABLE 8'h05
`define CMD_RX_ENABLE 8'h06
`define CMD_RX_DISABLE 8'h07
`define CMD_ENTER_SEARCH 8'h08

`define PSEL_MSB 2'h0
`define PSEL_MP 2'h1

`endif

/* serial_channel_pkg.sv */
// Types shared by the serial channel status block.
// Assumes serial_channel_defines.svh for the numeric constants.
package serial_channel_pkg;
    typedef enum logic [1:0] {
        MODE_ASYNC = 2'h0,
        MODE_BYTE_SYNC = 2'h1,
        MODE_BIT_SYNC = 2'h3
    } chan_mode_e;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_WRITE = 2'h1,
        BUS_READ = 2'h3
    } bus_phase_e;

    typedef logic [7:0] byte_t;
endpackage

/* serial_channel_rx_tx_status.sv */
// Receive and line status registers of one serial channel, on an AHB-Lite slave.
// Assumes receiver/transmitter events arrive as one-cycle pulses on hclk; modem lines are asynchronous pins.
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`include "serial_channel_defines.svh"

module serial_channel_rx_tx_status (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic system_stop,
    input wire logic char_ready,
    input wire logic char_parity,
    input wire logic char_mp,
    input wire logic char_msb,
    input wire logic char_parity_err,
    input wire logic char_framing_err,
    input wire logic overrun_evt,
    input wire logic frame_last_info,
    input wire logic frame_last_fcs,
    input wire logic frame_short,
    input wire logic frame_data_sent,
    input wire logic frame_residual,
    input wire logic frame_abort,
    input wire logic crc_checked,
    input wire logic crc_bad,
    input wire logic fst_load,
    input wire logic tx_active,
    input wire logic clock_missing_twice,
    input wire logic search_done,
    input wire logic cts_pin,
    input wire logic dcd_pin,
    output logic [7:0] mode_out,
    output logic crc_pass_to_buffer,
    output logic rx_reset_pulse,
    output logic tx_reset_pulse,
    output logic last_data_irq
);
    import serial_channel_pkg::*;

    typedef struct packed {
        byte_t rs;
        logic pmp_pending;
        logic pmp_next;
        logic searching;
        logic tx_en;
        logic rx_en;
        logic [1:0] cts_sync;
        logic [1:0] dcd_sync;
        byte_t mode;
        bus_phase_e phase;
        logic [11:0] addr;
        logic [31:0] rdata;
        logic rx_rst;
        logic tx_rst;
        logic irq;
    } state_s;

    state_s cur_ff;
    state_s nxt_ff;

    always_comb begin
        chan_mode_e md;
        logic bitsync;
        logic frame_end;
        logic rx_clr;
        logic all_clr;
        logic tx_clr;
        logic [7:0] cmd;
        logic [7:0] w1c;
        logic [7:0] set;
        logic [7:0] rs_view;
        logic [7:0] ls_view;
        logic sample_bit;
        sample_bit = 1'b0;
        md = chan_mode_e'(cur_ff.mode[`MC_MODE_LO +: 2]);
        bitsync = (md == MODE_BIT_SYNC);
        nxt_ff = cur_ff;
        nxt_ff.cts_sync = {cur_ff.cts_sync[0], cts_pin};
        nxt_ff.dcd_sync = {cur_ff.dcd_sync[0], dcd_pin};
        cmd = `CMD_NOP;
        w1c = 8'h00;
        if (cur_ff.phase == BUS_WRITE) begin
            if (cur_ff.addr == `OFF_COMMAND) begin
                cmd = hwdata[7:0];
            end else if (cur_ff.addr == `OFF_RECEIVE_STATUS) begin
                w1c = hwdata[7:0];
            end else if (cur_ff.addr == `OFF_MODE_CTRL) begin
                nxt_ff.mode = hwdata[7:0];
            end
            // Line status writes fall through untouched
        end
        all_clr = (cmd == `CMD_CH_RESET) || system_stop;
        rx_clr = all_clr || (cmd == `CMD_RX_RESET);
        tx_clr = all_clr || (cmd == `CMD_TX_RESET);

        // Frame end on last info char with pass, last FCS char without
        frame_end = cur_ff.mode[`MC_CRCPASS] ? frame_last_info : frame_last_fcs;
        set = 8'h00;
        if (bitsync) begin
            if (frame_end && frame_short && frame_data_sent) begin
                set[`RS_PMP] = 1'b1;
                set[`RS_EOM] = 1'b1;
            end
            if (frame_abort) begin
                // Abort end frame marks the character ahead of the abort
                // The receiver drops the bits lost to a late stuffed zero; only the flags land here
                set[`RS_PE] = 1'b1;
                set[`RS_EOM] = 1'b1;
            end
            if (frame_end && frame_residual) begin
                set[`RS_FRAMING_ERROR_FLAG] = 1'b1;
                set[`RS_EOM] = 1'b1;
            end
            if (frame_end) begin
                set[`RS_EOM] = 1'b1;
            end
        end else if (md == MODE_ASYNC && char_ready) begin
            set[`RS_PE] = char_parity_err;
            set[`RS_FRAMING_ERROR_FLAG] = char_framing_err;
        end
        set[`RS_OVERRUN_FLAG] = overrun_evt;
        if (md != MODE_ASYNC && cur_ff.mode[`MC_CRCPASS] && crc_checked && crc_bad) begin
            set[`RS_CRC_ERROR_FLAG] = 1'b1;
        end

        // Sticky bits: set wins over clear; CRC flag alone follows a good result
        w1c[`RS_CRC_ERROR_FLAG] = w1c[`RS_CRC_ERROR_FLAG] | (crc_checked && !crc_bad);
        w1c[`RS_PMP] = w1c[`RS_PMP] & bitsync;
        if (rx_clr || (bitsync && fst_load)) begin
            w1c = 8'hFF;
        end
        nxt_ff.rs = (cur_ff.rs & ~w1c) | set;

        // Async capture bit: value of this character shows once the next is ready
        if (md == MODE_ASYNC) begin
            case (cur_ff.mode[`MC_PSEL_LO +: 2])
                `PSEL_MSB: sample_bit = char_msb;
                `PSEL_MP: sample_bit = char_mp;
                default: sample_bit = char_parity;
            endcase
            if (char_ready) begin
                nxt_ff.pmp_next = sample_bit;
                nxt_ff.pmp_pending = 1'b1;
                if (cur_ff.pmp_pending) begin
                    nxt_ff.rs[`RS_PMP] = cur_ff.pmp_next;
                end
            end
            if (rx_clr) begin
                nxt_ff.pmp_pending = 1'b0;
                nxt_ff.rs[`RS_PMP] = 1'b0;
            end
        end

        // Search state
        if (cmd == `CMD_ENTER_SEARCH || clock_missing_twice) begin
            nxt_ff.searching = 1'b1;
        end else if (search_done) begin
            nxt_ff.searching = 1'b0;
        end
        if (cmd == `CMD_TX_ENABLE) nxt_ff.tx_en = 1'b1;
        if (cmd == `CMD_TX_DISABLE) nxt_ff.tx_en = 1'b0;
        if (cmd == `CMD_RX_ENABLE) nxt_ff.rx_en = 1'b1;
        if (cmd == `CMD_RX_DISABLE) nxt_ff.rx_en = 1'b0;
        // Search state is not a transmit bit, so of the resets only a full clear drops it
        if (tx_clr) begin
            nxt_ff.tx_en = 1'b0;
        end
        if (all_clr) nxt_ff.searching = 1'b0;
        if (rx_clr) nxt_ff.rx_en = 1'b0;
        if (all_clr) nxt_ff.mode = `MODE_CTRL_RESET;
        nxt_ff.rx_rst = rx_clr;
        nxt_ff.tx_rst = tx_clr;

        // Last-data interrupt on residual or aborted frame
        nxt_ff.irq = bitsync && (frame_abort || (frame_end && frame_residual));

        // Views: reserved and mode-dependent bits forced to 0
        rs_view = cur_ff.rs;
        rs_view[1:0] = 2'h0;
        if (md != MODE_BIT_SYNC) rs_view[`RS_EOM] = 1'b0;
        if (md == MODE_BYTE_SYNC) rs_view[6:4] = 3'h0;
        if (md == MODE_ASYNC) rs_view[`RS_CRC_ERROR_FLAG] = 1'b0;
        ls_view = 8'h00;
        ls_view[`LS_TXING] = bitsync && tx_active && !tx_clr;
        ls_view[`LS_SEARCH_MODE_INDICATOR] = (md != MODE_ASYNC) && cur_ff.searching;
        // Pins pass the synchroniser; a transmit reset blanks CTS and a receive reset blanks DCD for that cycle
        ls_view[`LS_CTS] = cur_ff.cts_sync[1] && !tx_clr;
        ls_view[`LS_DCD] = cur_ff.dcd_sync[1] && !rx_clr;
        ls_view[`LS_TXEN] = cur_ff.tx_en;
        ls_view[`LS_RXEN] = cur_ff.rx_en;

        // Address phase: zero-wait slave, always OKAY
        nxt_ff.phase = BUS_IDLE;
        nxt_ff.rdata = 32'h0000_0000;
        if (hsel && hready && htrans[1]) begin
            nxt_ff.addr = haddr[11:0];
            nxt_ff.phase = hwrite ? BUS_WRITE : BUS_READ;
            case (haddr[11:0])
                `OFF_RECEIVE_STATUS: nxt_ff.rdata = {24'h000000, rs_view};
                `OFF_LINE_STATUS: nxt_ff.rdata = {24'h000000, ls_view};
                `OFF_MODE_CTRL: nxt_ff.rdata = {24'h000000, cur_ff.mode};
                default: nxt_ff.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign hrdata = cur_ff.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign mode_out = cur_ff.mode;
    assign crc_pass_to_buffer = cur_ff.mode[`MC_CRCPASS];
    assign rx_reset_pulse = cur_ff.rx_rst;
    assign tx_reset_pulse = cur_ff.tx_rst;
    assign last_data_irq = cur_ff.irq;
endmodule

/* serial_channel_rx_tx_status_properties.sv */
// Checker for the serial channel status block: read data against mode and event inputs.
// Assumes it is bound to the block's top module and sees only its ports.
`include "serial_channel_defines.svh"
module scs_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic [7:0] mode_out,
    input wire logic frame_abort,
    input wire logic last_data_irq,
    input wire logic cts_pin,
    input wire logic tx_reset_pulse,
    input wire logic rx_reset_pulse
);
    import serial_channel_pkg::*;
    logic rd_ff;
    logic cts_ff;
    logic [11:0] ad_ff;
    logic [2:0] calm_ff;
    // Pin level is only judged once pin and reset pulses have been quiet long enough to pass the synchroniser
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ff <= 1'h0;
            ad_ff <= 12'h000;
            cts_ff <= 1'h0;
            calm_ff <= 3'h0;
        end else begin
            rd_ff <= hsel && hready && htrans[1] && !hwrite;
            ad_ff <= haddr[11:0];
            cts_ff <= cts_pin;
            calm_ff <= (tx_reset_pulse || rx_reset_pulse || cts_pin != cts_ff) ? 3'h0 : calm_ff + 3'(calm_ff != 3'h7);
        end
    end
    wire rs = rd_ff && ad_ff == `OFF_RECEIVE_STATUS;
    wire ls = rd_ff && ad_ff == `OFF_LINE_STATUS;
    wire asy = mode_out[1:0] == MODE_ASYNC;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ls_resv_a: assert property (ls |-> hrdata[7:6] == 2'h0) else $error("line reserved bits set");
    rs_low_a: assert property (rs |-> hrdata[1:0] == 2'h0) else $error("receive low bits set");
    byte_resv_a: assert property (rs && mode_out[1:0] == MODE_BYTE_SYNC |-> hrdata[6:4] == 3'h0)
        else $error("byte mode bits set");
    async_crc_a: assert property (rs && asy |-> !hrdata[2]) else $error("async crc bit set");
    async_tx_a: assert property (ls && asy |-> !hrdata[5]) else $error("async transmit bit set");
    async_search_mode_indicator_a: assert property (ls && asy |-> !hrdata[4]) else $error("async search bit set");
    cts_level_a: assert property (ls && calm_ff == 3'h7 |-> hrdata[3] == cts_pin) else $error("cts level wrong");
    abort_irq_a: assert property (frame_abort && mode_out[1:0] == MODE_BIT_SYNC |=> last_data_irq)
        else $error("no interrupt after abort");
endmodule

/* serial_channel_rx_tx_status_bench.sv */
// Self-checking bench for the serial channel status block over AHB-Lite.
// Assumes the design, its header and the checker file are compiled first.
`include "serial_channel_defines.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module serial_channel_rx_tx_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] RS = `OFF_RECEIVE_STATUS;
    localparam logic [11:0] LS = `OFF_LINE_STATUS;
    localparam logic [11:0] MC = `OFF_MODE_CTRL;
    logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0, char_parity = '0, char_mp = '0, char_msb = '0;
    logic char_parity_err = '0, char_framing_err = '0, frame_short = '0, frame_data_sent = '0, frame_residual = '0;
    logic crc_bad = '0, tx_active = '0, cts_pin = '0, dcd_pin = '0;
    logic hreadyout, hresp, rx_reset_pulse, tx_reset_pulse, last_data_irq, crc_pass_to_buffer;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = 3'h2;
    logic [9:0] ev_v = '0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [7:0] mode_out;
    int errors = 0, compares = 0;
    // One-cycle event pulses share a vector so a single task can raise any of them
    wire char_ready = ev_v[0], overrun_evt = ev_v[1], frame_last_info = ev_v[2], frame_last_fcs = ev_v[3];
    wire frame_abort = ev_v[4], crc_checked = ev_v[5], fst_load = ev_v[6], clock_missing_twice = ev_v[7];
    wire search_done = ev_v[8], system_stop = ev_v[9];
    wire hready = hreadyout;
    serial_channel_rx_tx_status i_dut (.*);
    initial forever #2 hclk = ~hclk;
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {20'h0, a};
        do @(posedge hclk); while (hready !== 1'h1 && ++n < 50);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'h1 && ++n < 99);
        rd = hrdata;
    endtask
    task automatic cmd(input logic [7:0] c);
        xfer(1'h1, `OFF_COMMAND, {24'h0, c});
    endtask
    task automatic chk(input logic [11:0] a, input logic [7:0] e);
        xfer(1'h0, a, 32'h0);
        `CHK(rd, {24'h0, e})
    endtask
    task automatic ev(input int i);
        ev_v[i] <= 1'h1;
        @(posedge hclk);
        ev_v[i] <= 1'h0;
    endtask
    task automatic t_reg();
        chk(LS, 8'h00);
        xfer(1'h1, LS, 32'hFF);
        chk(LS, 8'h00);
        chk(12'h010, 8'h00);
        $display("t_reg done");
    endtask
    task automatic t_par();
        for (int p = 0; p < 4; p++) begin
            xfer(1'h1, MC, 32'(p << 2));
            cmd(`CMD_RX_RESET);
            {char_parity, char_mp, char_msb} <= p[1] ? 3'h4 : (p[0] ? 3'h2 : 3'h1);
            ev(0);
            chk(RS, 8'h00);
            {char_parity, char_mp, char_msb} <= p[1] ? 3'h3 : (p[0] ? 3'h5 : 3'h6);
            ev(0);
            chk(RS, 8'h40);
        end
        $display("t_par done");
    endtask
    task automatic t_err(input logic [31:0] m, input logic [7:0] e);
        xfer(1'h1, MC, m);
        cmd(`CMD_RX_RESET);
        {char_msb, char_mp, char_parity, char_parity_err, char_framing_err, crc_bad} <= 6'h07;
        ev(0);
        ev(1);
        ev(5);
        {char_parity_err, char_framing_err, crc_bad} <= 3'h0;
        ev(0);
        chk(RS, e);
        xfer(1'h1, RS, 32'h2C);
        chk(RS, e & 8'h10);
        cmd(`CMD_RX_RESET);
        chk(RS, 8'h00);
        $display("t_err done");
    endtask
    task automatic t_bit();
        xfer(1'h1, MC, 32'h13);
        cmd(`CMD_RX_RESET);
        {frame_short, frame_data_sent} <= 2'h3;
        ev(2);
        chk(RS, 8'hC0);
        ev(6);
        chk(RS, 8'h00);
        frame_data_sent <= 1'h0;
        ev(2);
        chk(RS, 8'h80);
        {frame_short, frame_residual} <= 2'h1;
        ev(2);
        chk(RS, 8'h90);
        frame_residual <= 1'h0;
        ev(6);
        ev(4);
        chk(RS, 8'hA0);
        crc_bad <= 1'h1;
        ev(5);
        chk(RS, 8'hA4);
        crc_bad <= 1'h0;
        ev(5);
        chk(RS, 8'hA0);
        xfer(1'h1, MC, 32'h03);
        ev(6);
        {crc_bad, frame_short, frame_data_sent} <= 3'h7;
        ev(5);
        ev(3);
        chk(RS, 8'hC0);
        {crc_bad, frame_short, frame_data_sent} <= 3'h0;
        $display("t_bit done");
    endtask
    task automatic t_line();
        {cts_pin, dcd_pin, tx_active} <= 3'h7;
        cmd(`CMD_TX_ENABLE);
        cmd(`CMD_RX_ENABLE);
        cmd(`CMD_ENTER_SEARCH);
        repeat (3) @(posedge hclk);
        chk(LS, 8'h3F);
        tx_active <= 1'h0;
        cmd(`CMD_TX_RESET);
        repeat (3) @(posedge hclk);
        chk(LS, 8'h1D);
        cmd(`CMD_RX_RESET);
        repeat (3) @(posedge hclk);
        chk(LS, 8'h1C);
        ev(8);
        chk(LS, 8'h0C);
        ev(7);
        chk(LS, 8'h1C);
        cmd(`CMD_TX_ENABLE);
        cmd(`CMD_RX_ENABLE);
        cmd(`CMD_TX_DISABLE);
        chk(LS, 8'h1D);
        cmd(`CMD_RX_DISABLE);
        cmd(`CMD_TX_ENABLE);
        cmd(`CMD_CH_RESET);
        repeat (3) @(posedge hclk);
        chk(LS, 8'h0C);
        tx_active <= 1'h1;
        cmd(`CMD_RX_ENABLE);
        ev(9);
        repeat (3) @(posedge hclk);
        chk(LS, 8'h0C);
        {cts_pin, dcd_pin} <= 2'h0;
        repeat (9) @(posedge hclk);
        chk(LS, 8'h00);
        $display("t_line done");
    endtask
    task automatic end_of_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #40000;
        errors++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        t_reg();
        t_par();
        t_err(32'h10, 8'h38);
        t_err(32'h11, 8'h0C);
        t_bit();
        t_line();
        end_of_test();
    end
endmodule
bind serial_channel_rx_tx_status scs_checker i_chk (.*);
